// *** capture_record_pkg.sv ***
// Shared constants and types of the capture record writer
package capture_record_pkg;
  // Record types and extension header
  localparam logic [7:0] REC_TYPE_ETH = 8'h02;
  localparam logic [7:0] REC_TYPE_RAW_LINK = 8'h18;
  localparam logic [7:0] EXT_HDR_RAW_LINK = 8'h05;
  localparam logic [7:0] EXT_FLAG = 8'h80;
  localparam logic [7:0] SEQ_FIRST = 8'h00;
  localparam logic MORE_FRAG_NONE = 1'b0;
  localparam logic [7:0] FRAME_A1 = 8'hF6;
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_BASE = 12'h004;
  localparam logic [11:0] OFS_SIZE = 12'h008;
  localparam logic [11:0] OFS_RDPTR = 12'h00C;
  localparam logic [11:0] OFS_WRPTR = 12'h010;
  localparam logic [11:0] OFS_STAT = 12'h014;
  localparam logic [11:0] OFS_IRQ = 12'h018;
  localparam logic [11:0] OFS_MASK = 12'h01C;
  localparam logic [11:0] OFS_DROPS = 12'h020;
  // Control bits
  localparam int CTRL_EN = 0;
  localparam int CTRL_RAW = 1;
  // Interrupt bits
  localparam int IRQ_FULL = 0;
  localparam int IRQ_DROP = 1;
  localparam int IRQ_REC = 2;
  localparam int IRQ_W = 3;
  // Header words and indicator timing
  localparam logic [2:0] HDR_WORDS = 3'd4;
  localparam logic [31:0] WORD_BYTES = 32'd4;
  localparam int BLINK_US = 100000;
  localparam int CLK_MHZ = 125;
  localparam int BLINK_CYC = BLINK_US * CLK_MHZ;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } mem_wr_t;
endpackage

// *** capture_record_writer.sv ***
// Capture record writer: packet stream to circular host buffer
`timescale 1ns/1ps
module capture_record_writer
  import capture_record_pkg::*;
#(
  parameter int BLINK_CYCLES = BLINK_CYC,
  parameter int LEN_W = 16
)(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Captured packet stream, words of 32 bits
  input wire logic pkt_valid,
  input wire logic pkt_sop,
  input wire logic pkt_eop,
  input wire logic [31:0] pkt_data,
  input wire logic [LEN_W-1:0] pkt_len,
  output logic pkt_ready,
  // Host memory write port
  output mem_wr_t mem_wr,
  output logic mem_valid,
  input wire logic mem_ready,
  // Indicator and interrupt
  output logic activity_led,
  output logic irq
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HDR = 2'b01,
    ST_BODY = 2'b10,
    ST_DROP = 2'b11
  } wr_state_t;

  wr_state_t state_ff, nxt_state;
  logic [1:0] ctrl_ff, nxt_ctrl;
  logic [31:0] base_ff, nxt_base, size_ff, nxt_size;
  logic [31:0] rdptr_ff, nxt_rdptr, wrptr_ff, nxt_wrptr;
  logic [31:0] drops_ff, nxt_drops;
  logic [IRQ_W-1:0] irq_ff, nxt_irq, mask_ff, nxt_mask;
  logic [15:0] lctr_ff, nxt_lctr;
  logic [2:0] hcnt_ff, nxt_hcnt;
  logic [LEN_W-1:0] len_ff, nxt_len;
  logic [31:0] first_ff, nxt_first;
  logic first_wait_ff, nxt_first_wait;
  logic raw_ff, nxt_raw;
  logic [31:0] blink_ff, nxt_blink;
  logic led_ff, nxt_led;
  logic full_ff, nxt_full;
  mem_wr_t mem_ff, nxt_mem;
  logic mvalid_ff, nxt_mvalid;
  logic [31:0] prdata_ff, nxt_prdata;

  logic apb_acc, apb_wr, apb_rd, mapped;
  logic [31:0] used, free, rec_bytes, pad_len;
  logic fits, start, mem_take;

  assign apb_acc = psel && penable;
  assign apb_wr = apb_acc && pwrite;
  assign apb_rd = apb_acc && !pwrite;
  assign mem_take = !mvalid_ff || mem_ready;
  // Offsets run modulo the buffer size
  assign used = (wrptr_ff >= rdptr_ff) ? wrptr_ff - rdptr_ff
              : size_ff - rdptr_ff + wrptr_ff;
  assign free = size_ff - used;
  assign pad_len = (32'(pkt_len) + 32'd3) & ~32'd3;
  assign rec_bytes = {27'h0, HDR_WORDS, 2'b00} + pad_len;
  // Keep one word unused so full and empty stay distinct
  assign fits = free > rec_bytes;
  assign start = (state_ff == ST_IDLE) && pkt_valid && pkt_sop
              && ctrl_ff[CTRL_EN];
  // Opening word stays on the stream until its payload write, or the drop state, takes it
  assign pkt_ready = (state_ff == ST_DROP)
    || (state_ff == ST_IDLE && !(pkt_sop && pkt_valid))
    || (state_ff == ST_BODY && mem_take);

  always_comb
  begin
    case (paddr)
      OFS_CTRL, OFS_BASE, OFS_SIZE, OFS_RDPTR, OFS_WRPTR,
      OFS_STAT, OFS_IRQ, OFS_MASK, OFS_DROPS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  function automatic logic [31:0] wrap_add(input logic [31:0] p,
                                            input logic [31:0] s);
    logic [31:0] q;
    q = p + WORD_BYTES;
    wrap_add = (q >= s) ? 32'h0 : q;
  endfunction

  always_comb
  begin
    nxt_state = state_ff;
    nxt_ctrl = ctrl_ff;
    nxt_base = base_ff;
    nxt_size = size_ff;
    nxt_rdptr = rdptr_ff;
    nxt_wrptr = wrptr_ff;
    nxt_drops = drops_ff;
    nxt_mask = mask_ff;
    nxt_lctr = lctr_ff;
    nxt_hcnt = hcnt_ff;
    nxt_len = len_ff;
    nxt_first = first_ff;
    nxt_first_wait = first_wait_ff;
    nxt_raw = raw_ff;
    nxt_mem = mem_ff;
    nxt_mvalid = mvalid_ff && !mem_ready;
    nxt_prdata = prdata_ff;
    nxt_full = full_ff;
    nxt_irq = irq_ff;
    // Register writes; clear by one, event set below wins
    if (apb_wr)
    begin
      case (paddr)
        OFS_CTRL: nxt_ctrl = pwdata[1:0];
        OFS_BASE: nxt_base = pwdata & ~32'd3;
        OFS_SIZE: nxt_size = pwdata & ~32'd3;
        OFS_RDPTR: nxt_rdptr = pwdata & ~32'd3;
        OFS_IRQ: nxt_irq = irq_ff & ~pwdata[IRQ_W-1:0];
        OFS_MASK: nxt_mask = pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    if (apb_rd)
    begin
      case (paddr)
        OFS_CTRL: nxt_prdata = {30'h0, ctrl_ff};
        OFS_BASE: nxt_prdata = base_ff;
        OFS_SIZE: nxt_prdata = size_ff;
        OFS_RDPTR: nxt_prdata = rdptr_ff;
        OFS_WRPTR: nxt_prdata = wrptr_ff;
        OFS_STAT: nxt_prdata = {31'h0, full_ff};
        OFS_IRQ: nxt_prdata = {29'h0, irq_ff};
        OFS_MASK: nxt_prdata = {29'h0, mask_ff};
        OFS_DROPS: nxt_prdata = drops_ff;
        default: nxt_prdata = 32'h0;
      endcase
    end
    case (state_ff)
      ST_IDLE:
      begin
        if (start)
        begin
          if (fits)
          begin
            nxt_state = ST_HDR;
            nxt_hcnt = 3'd0;
            nxt_len = pkt_len;
            nxt_first = pkt_data;
            nxt_first_wait = 1'b1;
            nxt_raw = ctrl_ff[CTRL_RAW];
            nxt_full = 1'b0;
          end
          else
          begin
            // Opening word of a dropped frame is swallowed in the drop state
            nxt_state = ST_DROP;
            nxt_full = 1'b1;
            nxt_irq[IRQ_FULL] = 1'b1;
            nxt_irq[IRQ_DROP] = 1'b1;
            nxt_drops = drops_ff + 32'd1;
            if (lctr_ff != 16'hFFFF)
              nxt_lctr = lctr_ff + 16'd1;
          end
        end
        else if (full_ff && fits)
          nxt_full = 1'b0;
      end
      ST_HDR:
      begin
        if (mem_take)
        begin
          nxt_mvalid = 1'b1;
          nxt_mem.addr = base_ff + wrptr_ff;
          nxt_wrptr = wrap_add(wrptr_ff, size_ff);
          nxt_hcnt = hcnt_ff + 3'd1;
          case (hcnt_ff)
            // Type, flags and loss count in one word
            3'd0: nxt_mem.data = {nxt_raw_type(raw_ff), 8'h00,
                                  lctr_ff};
            3'd1: nxt_mem.data = {16'h0000, rec_len16(len_ff)};
            // Extension header, whole frame in one record
            3'd2: nxt_mem.data = raw_ff ? {EXT_HDR_RAW_LINK,
                    MORE_FRAG_NONE, 7'h00, SEQ_FIRST, 8'h00}
                    : 32'h0;
            default: nxt_mem.data = 32'h0;
          endcase
          if (hcnt_ff == 3'd0)
            nxt_lctr = 16'h0000;
          if (hcnt_ff == HDR_WORDS - 3'd1)
            nxt_state = ST_BODY;
        end
      end
      ST_BODY:
      begin
        // Gaps on the stream must not move the write pointer
        if (mem_take && pkt_valid)
        begin
          nxt_mvalid = 1'b1;
          nxt_mem.addr = base_ff + wrptr_ff;
          nxt_wrptr = wrap_add(wrptr_ff, size_ff);
          // Payload begins with the word that opened the frame
          nxt_mem.data = first_wait_ff ? first_ff : pkt_data;
          nxt_first_wait = 1'b0;
          if (pkt_eop)
          begin
            nxt_state = ST_IDLE;
            nxt_irq[IRQ_REC] = 1'b1;
          end
        end
      end
      ST_DROP:
        if (pkt_valid && pkt_eop)
          nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  function automatic logic [7:0] nxt_raw_type(input logic raw);
    nxt_raw_type = raw ? (REC_TYPE_RAW_LINK | EXT_FLAG) : REC_TYPE_ETH;
  endfunction

  function automatic logic [15:0] rec_len16(input logic [LEN_W-1:0] l);
    logic [31:0] r;
    r = {27'h0, HDR_WORDS, 2'b00} + 32'(l);
    rec_len16 = r[15:0];
  endfunction

  // Indicator: steady on when capturing, blinking while full
  always_comb
  begin
    nxt_blink = blink_ff + 32'd1;
    nxt_led = led_ff;
    if (blink_ff >= 32'(BLINK_CYCLES - 1))
    begin
      nxt_blink = 32'h0;
      nxt_led = !led_ff;
    end
    if (!full_ff)
      nxt_led = ctrl_ff[CTRL_EN];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= ST_IDLE;
      ctrl_ff <= 2'b00;
      base_ff <= 32'h0;
      size_ff <= 32'h0;
      rdptr_ff <= 32'h0;
      wrptr_ff <= 32'h0;
      drops_ff <= 32'h0;
      irq_ff <= '0;
      mask_ff <= '0;
      lctr_ff <= 16'h0000;
      hcnt_ff <= 3'd0;
      len_ff <= '0;
      first_ff <= 32'h0;
      first_wait_ff <= 1'b0;
      raw_ff <= 1'b0;
      blink_ff <= 32'h0;
      led_ff <= 1'b0;
      full_ff <= 1'b0;
      mem_ff <= '0;
      mvalid_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      ctrl_ff <= nxt_ctrl;
      base_ff <= nxt_base;
      size_ff <= nxt_size;
      rdptr_ff <= nxt_rdptr;
      wrptr_ff <= nxt_wrptr;
      drops_ff <= nxt_drops;
      irq_ff <= nxt_irq;
      mask_ff <= nxt_mask;
      lctr_ff <= nxt_lctr;
      hcnt_ff <= nxt_hcnt;
      len_ff <= nxt_len;
      first_ff <= nxt_first;
      first_wait_ff <= nxt_first_wait;
      raw_ff <= nxt_raw;
      blink_ff <= nxt_blink;
      led_ff <= nxt_led;
      full_ff <= nxt_full;
      mem_ff <= nxt_mem;
      mvalid_ff <= nxt_mvalid;
      prdata_ff <= nxt_prdata;
    end
  end

  // Read data lags one cycle, so the slave waits one cycle
  logic wait_ff, nxt_wait;
  always_comb
  begin
    nxt_wait = apb_acc && !wait_ff;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wait_ff <= 1'b0;
    else
      wait_ff <= nxt_wait;
  end

  assign pready = !apb_rd || wait_ff;
  assign pslverr = apb_acc && pready && !mapped;
  assign prdata = prdata_ff;
  assign mem_wr = mem_ff;
  assign mem_valid = mvalid_ff;
  assign activity_led = led_ff;
  assign irq = |(irq_ff & mask_ff);
endmodule

// *** capture_record_writer_sva.sv ***
// Port-level checker for the capture record writer
`timescale 1ns/1ps
module capture_record_writer_sva
  import capture_record_pkg::*;
#(
  parameter int BLINK_CYCLES = BLINK_CYC,
  parameter int LEN_W = 16
)(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Packet stream
  input wire logic pkt_valid,
  input wire logic pkt_sop,
  input wire logic pkt_eop,
  input wire logic [31:0] pkt_data,
  input wire logic [LEN_W-1:0] pkt_len,
  input wire logic pkt_ready,
  // Memory port, indicator, interrupt
  input wire mem_wr_t mem_wr,
  input wire logic mem_valid,
  input wire logic mem_ready,
  input wire logic activity_led,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wr_zero_wait_a: assert property (psel && penable && pwrite |-> pready)
    else $error("write access stalled");
  rd_first_wait_a: assert property ($rose(penable) && psel && !pwrite
    |-> !pready) else $error("read answered without wait state");
  rd_one_wait_a: assert property (psel && penable && !pwrite && !pready
    |=> pready) else $error("read wait state too long");
  bad_addr_err_a: assert property (psel && penable && pready
    && paddr > OFS_DROPS |-> pslverr) else $error("unmapped not refused");
  good_addr_ok_a: assert property (psel && penable && pready
    && paddr == OFS_WRPTR |-> !pslverr) else $error("mapped refused");
  rd_data_hold_a: assert property (!(psel && !pwrite) |=> $stable(prdata))
    else $error("read data moved outside a read");
  mem_word_hold_a: assert property (mem_valid && !mem_ready
    |=> mem_valid && $stable(mem_wr)) else $error("memory word dropped");
  mask_irq_off_a: assert property (psel && penable && pwrite
    && paddr == OFS_MASK && pwdata == 32'h0 |=> !irq)
    else $error("masked interrupt still high");
  cover property (mem_valid && mem_wr.data[31:24] == 8'h98);
  cover property (pslverr);
  cover property (mem_valid && !mem_ready);
endmodule
bind capture_record_writer capture_record_writer_sva #(
  .BLINK_CYCLES(BLINK_CYCLES), .LEN_W(LEN_W)) i_capture_record_writer_sva (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .pkt_valid, .pkt_sop, .pkt_eop, .pkt_data, .pkt_len,
  .pkt_ready, .mem_wr, .mem_valid, .mem_ready, .activity_led, .irq);

// *** host_mem.sv ***
// Host memory model taking record words, with optional stalls
`timescale 1ns/1ps
module host_mem
  import capture_record_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Write port and stall control
  input wire mem_wr_t mem_wr,
  input wire logic mem_valid,
  input wire logic slow,
  output logic mem_ready
);
  logic [31:0] m [0:15];
  // Stall every other cycle so held words get exercised
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mem_ready <= 1'b1;
    else
      mem_ready <= slow ? ~mem_ready : 1'b1;
  end
  always_ff @(posedge pclk)
  begin
    if (mem_valid && mem_ready)
      m[mem_wr.addr[5:2]] <= mem_wr.data;
  end
endmodule

// *** tb.sv ***
// Self-checking bench for the capture record writer
`timescale 1ns/1ps
module tb;
  import capture_record_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pkt_valid = 1'b0, pkt_sop = 1'b0, pkt_eop = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, pkt_data = 32'h0, prdata, rd_q;
  logic [15:0] pkt_len = 16'h0008;
  logic pready, pslverr, pkt_ready, mem_valid, mem_ready;
  logic activity_led, irq, rd_err, led_q, slow = 1'b0;
  mem_wr_t mem_wr;
  int err_count = 0, samples_checked = 0, tog = 0;
  capture_record_writer #(.BLINK_CYCLES(4), .LEN_W(16))
    i_capture_record_writer (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .pkt_valid, .pkt_sop,
    .pkt_eop, .pkt_data, .pkt_len, .pkt_ready, .mem_wr, .mem_valid,
    .mem_ready, .activity_led, .irq);
  host_mem i_host_mem (.pclk, .presetn, .mem_wr, .mem_valid, .slow,
    .mem_ready);
  initial
  begin
    forever #4 pclk = ~pclk;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bounded wait, sampled mid-cycle away from the launching edge
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    @(negedge pclk);
    while (s !== 1'b1 && n < 300)
    begin
      @(negedge pclk);
      n++;
    end
    if (n >= 300)
    begin
      err_count++;
      $display("ERROR at %0t: wait timed out", $time);
      tally_and_finish();
    end
  endtask
  // Last word reaches memory a few cycles after its interrupt
  task automatic wait_rec();
    wait_hi(irq);
    repeat (3) @(negedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    wait_hi(pready);
    rd_q = prdata;
    rd_err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    // Let the access settle before outputs are looked at
    @(negedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_q, exp);
  endtask
  task automatic pkt(input logic [31:0] d0, input logic [31:0] d1);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge pclk);
      pkt_valid <= 1'b1;
      pkt_sop <= (i == 0);
      pkt_eop <= (i == 1);
      pkt_data <= i ? d1 : d0;
      wait_hi(pkt_ready);
    end
    @(posedge pclk);
    pkt_valid <= 1'b0;
  endtask
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_WRPTR, 32'h0);
    apb(1'b0, 12'h040, 32'h0);
    chk(rd_q, 32'h0);
    chk(rd_err, 32'h1);
    apb(1'b1, OFS_BASE, 32'h100);
    apb(1'b1, OFS_SIZE, 32'd52);
    apb(1'b1, OFS_MASK, 32'h7);
    apb(1'b1, OFS_CTRL, 32'h1);
    pkt(32'h11223344, 32'h55667788);
    wait_rec();
    chk(i_host_mem.m[0], {REC_TYPE_ETH, 24'h0});
    chk(i_host_mem.m[1], 32'h18);
    chk(i_host_mem.m[5], 32'h55667788);
    rd(OFS_IRQ, 32'h4);
    apb(1'b1, OFS_IRQ, 32'h7);
    chk(irq, 32'h0);
    chk(activity_led, 32'h1);
    $display("test plain record done");
    slow <= 1'b1;
    apb(1'b1, OFS_CTRL, 32'h3);
    pkt({FRAME_A1, 24'hF62801}, 32'h0BADF00D);
    wait_rec();
    chk(i_host_mem.m[6], {REC_TYPE_RAW_LINK | EXT_FLAG, 24'h0});
    chk(i_host_mem.m[8], {EXT_HDR_RAW_LINK, MORE_FRAG_NONE, 7'h00,
      SEQ_FIRST, 8'h00});
    chk(i_host_mem.m[10], {FRAME_A1, 24'hF62801});
    rd(OFS_WRPTR, 32'd48);
    $display("test raw frame done");
    apb(1'b1, OFS_IRQ, 32'h7);
    pkt(32'h1, 32'h2);
    wait_hi(irq);
    rd(OFS_WRPTR, 32'd48);
    rd(OFS_DROPS, 32'h1);
    rd(OFS_STAT, 32'h1);
    led_q = activity_led;
    repeat (20)
    begin
      @(negedge pclk);
      tog += (activity_led !== led_q);
      led_q = activity_led;
    end
    chk(tog > 2, 32'h1);
    apb(1'b1, OFS_MASK, 32'h0);
    chk(irq, 32'h0);
    $display("test overflow done");
    // Host drains up to the write pointer
    apb(1'b1, OFS_RDPTR, 32'd48);
    apb(1'b1, OFS_IRQ, 32'h7);
    apb(1'b1, OFS_MASK, 32'h4);
    apb(1'b1, OFS_CTRL, 32'h1);
    pkt(32'h11223344, 32'h55667788);
    wait_rec();
    chk(i_host_mem.m[12], {REC_TYPE_ETH, 24'h1});
    chk(i_host_mem.m[3], 32'h11223344);
    rd(OFS_WRPTR, 32'd20);
    apb(1'b1, OFS_IRQ, 32'h7);
    pkt(32'h1, 32'h2);
    wait_rec();
    chk(i_host_mem.m[5], {REC_TYPE_ETH, 24'h0});
    $display("test resume done");
    tally_and_finish();
  end
endmodule
